// ===== hw/mio_pkg.sv
// Constants shared by the motion input/output configuration block.
package mio_pkg;

   // ---------------------------------------------------------------
   // Bus widths
   // ---------------------------------------------------------------
   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;

   // ---------------------------------------------------------------
   // Register byte offsets
   // ---------------------------------------------------------------
   localparam logic [7:0] OFS_CFG = 8'h00;
   localparam logic [7:0] OFS_RB0 = 8'h04;
   localparam logic [7:0] OFS_RB1 = 8'h08;
   localparam logic [7:0] OFS_RB2 = 8'h0C;
   localparam logic [7:0] OFS_RB3 = 8'h10;
   localparam logic [7:0] OFS_RB4 = 8'h14;
   localparam logic [7:0] OFS_RB5 = 8'h18;
   localparam logic [7:0] OFS_STAT = 8'h1C;
   localparam logic [7:0] OFS_MASK = 8'h20;
   localparam logic [7:0] OFS_OUT_PORT = 8'h24;
   localparam logic [7:0] OFS_OUT_SET = 8'h28;
   localparam logic [7:0] OFS_OUT_CLR = 8'h2C;
   localparam logic [7:0] OFS_OUT_BIT = 8'h30;
   localparam logic [7:0] OFS_IN = 8'h34;

   // ---------------------------------------------------------------
   // Configuration fields: six signed nibbles, argument k at bits 4k+3:4k
   // ---------------------------------------------------------------
   localparam int FLD_W = 4;
   localparam int FLD_N = 6;
   localparam int FLD_LIMIT = 0;
   localparam int FLD_HOME = 1;
   localparam int FLD_LATCH = 2;
   localparam int FLD_SELAB = 3;
   localparam int FLD_ABORT = 4;
   localparam int FLD_AMPMAP = 5;
   localparam logic [3:0] NIB_POS = 4'h1;
   localparam logic [3:0] NIB_NEG = 4'hF;
   localparam logic [3:0] NIB_ZERO = 4'h0;
   localparam logic [23:0] CFG_RST = 24'h000FFF;

   // ---------------------------------------------------------------
   // Status and mask bits
   // ---------------------------------------------------------------
   localparam int ST_W = 4;
   localparam int ST_LIMIT = 0;
   localparam int ST_LATCH = 1;
   localparam int ST_SELAB = 2;
   localparam int ST_ABORT = 3;

   // ---------------------------------------------------------------
   // Digital outputs
   // ---------------------------------------------------------------
   localparam int DOUT_W = 8;
   localparam int OUT_AMP_IDX = 3;
   localparam int OB_VAL_POS = 8;
   localparam logic [3:0] OUT_NUM_MIN = 4'h1;
   localparam logic [3:0] OUT_NUM_MAX = 4'h8;

endpackage

// ===== hw/mio_sync.sv
// Two flip-flop synchroniser for a bundle of pin inputs.
`timescale 1ns/1ps
`default_nettype none
module mio_sync #(
   parameter int WIDTH = 8
) (
   input wire logic i_clk,
   input wire logic i_rst_n,
   input wire logic [WIDTH-1:0] i_d,
   output logic [WIDTH-1:0] o_q
);

   // ---------------------------------------------------------------
   // Synchroniser stages
   // ---------------------------------------------------------------
   logic [WIDTH-1:0] meta_ff;
   logic [WIDTH-1:0] sync_ff;

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         meta_ff <= '0;
         sync_ff <= '0;
      end else begin
         meta_ff <= i_d;
         sync_ff <= meta_ff;
      end
   end

   assign o_q = sync_ff;

endmodule // mio_sync
`default_nettype wire

// ===== hw/mio_top.sv
// Input polarity, selective abort and output-4 mapping for a motion controller.
// What this block does
// - Limit inputs active high on 1, low on -1
// - Home high drives forward on 1, backward -1
// - Latch input active high on 1, low -1
// - Selective abort inputs mapped to axes when enabled
// - Selective abort starts position error routine while running
// - Abort stops program unless fifth argument is 1
// - Output 4 becomes amplifier enable when mapped
// - Dedicated amplifier enable unaffected by the mapping
// - Mapped output 4 follows servo on state
// - Output writes to mapped output 4 ignored
// - Six readbacks return last accepted arguments
//
// The implementer's own choices: the plain strobed port and the address map.
`timescale 1ns/1ps
`default_nettype none
module mio_top #(
   parameter int AXES = 8,
   parameter int GPIN_W = 16
) (
   input wire logic I_CLK,
   input wire logic I_RSTN,
   input wire logic [7:0] I_ADDR,
   input wire logic [31:0] I_WDATA,
   input wire logic I_WR,
   input wire logic I_RD,
   output logic [31:0] O_RDATA,
   input wire logic [AXES-1:0] I_LIM_FWD,
   input wire logic [AXES-1:0] I_LIM_REV,
   input wire logic [AXES-1:0] I_HOME,
   input wire logic [AXES-1:0] I_LATCH,
   input wire logic [GPIN_W-1:0] I_GPIN,
   input wire logic I_ABORT,
   input wire logic I_PROG_RUN,
   input wire logic I_SERVO_ON,
   output logic [AXES-1:0] O_LIM_FWD_ACT,
   output logic [AXES-1:0] O_LIM_REV_ACT,
   output logic [AXES-1:0] O_HOME_FWD,
   output logic [AXES-1:0] O_LATCH_ACT,
   output logic [7:0] O_SEL_ABORT,
   output logic [GPIN_W-1:0] O_GPIN,
   output logic O_LIMIT_EVENT,
   output logic O_PROG_STOP,
   output logic O_POSITION_ERROR_ROUTINE_START,
   output logic O_AMP_EN,
   output logic [7:0] O_DOUT,
   output logic O_IRQ
);

   // ---------------------------------------------------------------
   // Functions
   // ---------------------------------------------------------------
   function automatic logic [3:0] fld(input logic [23:0] cfg, input int k);
      fld = cfg[k*mio_pkg::FLD_W +: mio_pkg::FLD_W];
   endfunction

   function automatic logic legal_sign(input logic [3:0] n);
      legal_sign = (n == mio_pkg::NIB_POS) || (n == mio_pkg::NIB_NEG);
   endfunction

   function automatic logic legal_flag(input logic [3:0] n);
      legal_flag = (n == mio_pkg::NIB_POS) || (n == mio_pkg::NIB_ZERO);
   endfunction

   function automatic logic [31:0] sext(input logic [3:0] n);
      sext = {{28{n[3]}}, n};
   endfunction

   function automatic logic [7:0] sel_map(input logic [15:0] g);
      sel_map = {g[15:12], g[7:4]};
   endfunction

   function automatic logic out_hit(input logic [3:0] num);
      out_hit = (num >= mio_pkg::OUT_NUM_MIN) && (num <= mio_pkg::OUT_NUM_MAX);
   endfunction

   // ---------------------------------------------------------------
   // Reset release
   // ---------------------------------------------------------------
   logic rst_meta_ff;
   logic rst_n;
   logic [4:0] settle_ff;

   // Limit and latch events are held off until the synchronisers carry real pin samples.
   always_ff @(posedge I_CLK or negedge I_RSTN) begin
      if (!I_RSTN) begin
         rst_meta_ff <= 1'b0;
         rst_n <= 1'b0;
         settle_ff <= 5'h00;
      end else begin
         rst_meta_ff <= 1'b1;
         rst_n <= rst_meta_ff;
         settle_ff <= {settle_ff[3:0], 1'b1};
      end
   end

   // ---------------------------------------------------------------
   // Pin synchronisation
   // ---------------------------------------------------------------
   localparam int PIN_W = 4 * AXES + GPIN_W + 1;
   logic [PIN_W-1:0] pins_s;
   logic [AXES-1:0] lim_fwd_s;
   logic [AXES-1:0] lim_rev_s;
   logic [AXES-1:0] home_s;
   logic [AXES-1:0] latch_s;
   logic [GPIN_W-1:0] gpin_s;
   logic abort_s;

   mio_sync #(.WIDTH(PIN_W)) u_sync (
      .i_clk(I_CLK),
      .i_rst_n(rst_n),
      .i_d({I_LIM_FWD, I_LIM_REV, I_HOME, I_LATCH, I_GPIN, I_ABORT}),
      .o_q(pins_s)
   );

   assign {lim_fwd_s, lim_rev_s, home_s, latch_s, gpin_s, abort_s} = pins_s;

   // ---------------------------------------------------------------
   // Configuration register
   // ---------------------------------------------------------------
   logic [23:0] cfg_ff;
   logic wr_cfg;
   logic lim_hi;
   logic home_fwd;
   logic latch_hi;
   logic sel_en;
   logic abort_keep;
   logic amp_map;

   assign wr_cfg = I_WR && (I_ADDR == mio_pkg::OFS_CFG);
   assign lim_hi = fld(cfg_ff, mio_pkg::FLD_LIMIT) == mio_pkg::NIB_POS;
   assign home_fwd = fld(cfg_ff, mio_pkg::FLD_HOME) == mio_pkg::NIB_POS;
   assign latch_hi = fld(cfg_ff, mio_pkg::FLD_LATCH) == mio_pkg::NIB_POS;
   assign sel_en = fld(cfg_ff, mio_pkg::FLD_SELAB) == mio_pkg::NIB_POS;
   assign abort_keep = fld(cfg_ff, mio_pkg::FLD_ABORT) == mio_pkg::NIB_POS;
   assign amp_map = fld(cfg_ff, mio_pkg::FLD_AMPMAP) == mio_pkg::NIB_POS;

   // Fields carrying an illegal value are left as they were.
   always_ff @(posedge I_CLK or negedge rst_n) begin
      if (!rst_n) begin
         cfg_ff <= mio_pkg::CFG_RST;
      end else if (wr_cfg) begin
         for (int k = 0; k < mio_pkg::FLD_N; k++) begin
            if ((k < mio_pkg::FLD_SELAB) ? legal_sign(fld(I_WDATA[23:0], k))
                                         : legal_flag(fld(I_WDATA[23:0], k))) begin
               cfg_ff[k*mio_pkg::FLD_W +: mio_pkg::FLD_W] <= fld(I_WDATA[23:0], k);
            end
         end
      end
   end

   // ---------------------------------------------------------------
   // Switch polarity
   // ---------------------------------------------------------------
   logic [AXES-1:0] nxt_lim_fwd;
   logic [AXES-1:0] nxt_lim_rev;

   assign nxt_lim_fwd = lim_hi ? lim_fwd_s : ~lim_fwd_s;
   assign nxt_lim_rev = lim_hi ? lim_rev_s : ~lim_rev_s;

   always_ff @(posedge I_CLK or negedge rst_n) begin
      if (!rst_n) begin
         O_LIM_FWD_ACT <= '0;
         O_LIM_REV_ACT <= '0;
         O_HOME_FWD <= '0;
         O_LATCH_ACT <= '0;
         O_LIMIT_EVENT <= 1'b0;
      end else begin
         O_LIM_FWD_ACT <= nxt_lim_fwd;
         O_LIM_REV_ACT <= nxt_lim_rev;
         O_HOME_FWD <= home_fwd ? home_s : ~home_s;
         O_LATCH_ACT <= latch_hi ? latch_s : ~latch_s;
         O_LIMIT_EVENT <= settle_ff[4]
            && |((nxt_lim_fwd & ~O_LIM_FWD_ACT) | (nxt_lim_rev & ~O_LIM_REV_ACT));
      end
   end

   // ---------------------------------------------------------------
   // Selective abort and abort input
   // ---------------------------------------------------------------
   logic [7:0] sel_d_ff;
   logic abort_d_ff;
   logic [7:0] sel_rise;
   logic abort_rise;

   assign sel_rise = O_SEL_ABORT & ~sel_d_ff;
   assign abort_rise = abort_s & ~abort_d_ff;

   always_ff @(posedge I_CLK or negedge rst_n) begin
      if (!rst_n) begin
         O_SEL_ABORT <= 8'h00;
         O_GPIN <= '0;
         sel_d_ff <= 8'h00;
         abort_d_ff <= 1'b0;
         O_POSITION_ERROR_ROUTINE_START <= 1'b0;
         O_PROG_STOP <= 1'b0;
      end else begin
         O_SEL_ABORT <= sel_en ? sel_map(gpin_s) : 8'h00;
         O_GPIN <= sel_en ? (gpin_s & ~16'hF0F0) : gpin_s;
         sel_d_ff <= O_SEL_ABORT;
         abort_d_ff <= abort_s;
         O_POSITION_ERROR_ROUTINE_START <= sel_en && I_PROG_RUN && (|sel_rise);
         O_PROG_STOP <= abort_rise && !abort_keep;
      end
   end

   // ---------------------------------------------------------------
   // Digital outputs and amplifier enable
   // ---------------------------------------------------------------
   logic [7:0] gpo_ff;
   logic [7:0] keep4;
   logic [3:0] out_num;
   logic [2:0] out_idx;

   assign keep4 = amp_map ? (8'h01 << mio_pkg::OUT_AMP_IDX) : 8'h00;
   assign out_num = I_WDATA[3:0];
   assign out_idx = 3'(out_num - 4'h1);

   always_ff @(posedge I_CLK or negedge rst_n) begin
      if (!rst_n) begin
         gpo_ff <= 8'h00;
      end else if (I_WR) begin
         unique case (I_ADDR)
            mio_pkg::OFS_OUT_PORT: begin
               gpo_ff <= (gpo_ff & keep4) | (I_WDATA[7:0] & ~keep4);
            end
            mio_pkg::OFS_OUT_SET: begin
               if (out_hit(out_num) && !keep4[out_idx]) begin
                  gpo_ff[out_idx] <= 1'b1;
               end
            end
            mio_pkg::OFS_OUT_CLR: begin
               if (out_hit(out_num) && !keep4[out_idx]) begin
                  gpo_ff[out_idx] <= 1'b0;
               end
            end
            mio_pkg::OFS_OUT_BIT: begin
               if (out_hit(out_num) && !keep4[out_idx]) begin
                  gpo_ff[out_idx] <= I_WDATA[mio_pkg::OB_VAL_POS];
               end
            end
            default: begin
               gpo_ff <= gpo_ff;
            end
         endcase
      end
   end

   always_ff @(posedge I_CLK or negedge rst_n) begin
      if (!rst_n) begin
         O_AMP_EN <= 1'b0;
         O_DOUT <= 8'h00;
      end else begin
         O_AMP_EN <= I_SERVO_ON;
         O_DOUT <= amp_map ? ((gpo_ff & ~keep4) | ({8{I_SERVO_ON}} & keep4)) : gpo_ff;
      end
   end

   // ---------------------------------------------------------------
   // Event status, mask and interrupt
   // ---------------------------------------------------------------
   logic [3:0] stat_ff;
   logic [3:0] mask_ff;
   logic [3:0] ev;
   logic [3:0] stat_clr;
   logic [AXES-1:0] latch_d_ff;

   assign ev = {abort_rise, |sel_rise, settle_ff[4] && |(O_LATCH_ACT & ~latch_d_ff), O_LIMIT_EVENT};
   assign stat_clr = (I_WR && I_ADDR == mio_pkg::OFS_STAT) ? I_WDATA[3:0] : 4'h0;

   always_ff @(posedge I_CLK or negedge rst_n) begin
      if (!rst_n) begin
         latch_d_ff <= '0;
         stat_ff <= 4'h0;
         mask_ff <= 4'h0;
         O_IRQ <= 1'b0;
      end else begin
         latch_d_ff <= O_LATCH_ACT;
         stat_ff <= (stat_ff & ~stat_clr) | ev;
         if (I_WR && I_ADDR == mio_pkg::OFS_MASK) begin
            mask_ff <= I_WDATA[3:0];
         end
         O_IRQ <= |(stat_ff & mask_ff);
      end
   end

   // ---------------------------------------------------------------
   // Read port
   // ---------------------------------------------------------------
   always_ff @(posedge I_CLK or negedge rst_n) begin
      if (!rst_n) begin
         O_RDATA <= 32'h0000_0000;
      end else if (!I_RD) begin
         O_RDATA <= 32'h0000_0000;
      end else begin
         unique case (I_ADDR)
            mio_pkg::OFS_CFG: O_RDATA <= {8'h00, cfg_ff};
            mio_pkg::OFS_RB0: O_RDATA <= sext(fld(cfg_ff, 0));
            mio_pkg::OFS_RB1: O_RDATA <= sext(fld(cfg_ff, 1));
            mio_pkg::OFS_RB2: O_RDATA <= sext(fld(cfg_ff, 2));
            mio_pkg::OFS_RB3: O_RDATA <= sext(fld(cfg_ff, 3));
            mio_pkg::OFS_RB4: O_RDATA <= sext(fld(cfg_ff, 4));
            mio_pkg::OFS_RB5: O_RDATA <= sext(fld(cfg_ff, 5));
            mio_pkg::OFS_STAT: O_RDATA <= {28'h0000000, stat_ff};
            mio_pkg::OFS_MASK: O_RDATA <= {28'h0000000, mask_ff};
            mio_pkg::OFS_OUT_PORT: O_RDATA <= {24'h000000, O_DOUT};
            mio_pkg::OFS_IN: O_RDATA <= {16'h0000, O_GPIN};
            default: O_RDATA <= 32'h0000_0000;
         endcase
      end
   end

   // ---------------------------------------------------------------
   // Assertions
   // ---------------------------------------------------------------
   default clocking cb @(posedge I_CLK); endclocking
   default disable iff (!rst_n);

   sequence sel_trig_s;
      sel_en && I_PROG_RUN && (|sel_rise);
   endsequence

   sequence map_write_s;
      amp_map && I_WR && (I_ADDR == mio_pkg::OFS_OUT_SET || I_ADDR == mio_pkg::OFS_OUT_CLR);
   endsequence

   AST_LIMIT_POL: assert property (
      rst_n && !lim_hi ##1 !lim_hi |-> O_LIM_FWD_ACT == ~$past(lim_fwd_s))
      else $error("Limit polarity not applied.");

   AST_HOME_DIR: assert property (
      home_fwd |=> O_HOME_FWD == $past(home_s))
      else $error("Home direction wrong.");

   AST_LATCH_POL: assert property (
      rst_n && !latch_hi |=> O_LATCH_ACT == ~$past(latch_s))
      else $error("Latch polarity wrong.");

   AST_SEL_OFF: assert property (
      !sel_en |=> O_SEL_ABORT == 8'h00)
      else $error("Selective abort active while disabled.");

   AST_POSITION_ERROR_ROUTINE: assert property (
      sel_trig_s |=> O_POSITION_ERROR_ROUTINE_START ##1 !O_POSITION_ERROR_ROUTINE_START || $past(|sel_rise))
      else $error("Position error start missing.");

   AST_PROG_STOP: assert property (
      O_PROG_STOP |-> $past(!abort_keep) && $past(abort_rise))
      else $error("Program stop without cause.");

   AST_AMP_EN: assert property (
      I_SERVO_ON ##1 I_SERVO_ON |=> O_AMP_EN [*1])
      else $error("Amplifier enable does not follow servo state.");

   AST_OUT4_MAP: assert property (
      amp_map |=> O_DOUT[mio_pkg::OUT_AMP_IDX] == O_AMP_EN)
      else $error("Output 4 does not track amplifier enable.");

   AST_OUT4_LOCK: assert property (
      map_write_s |=> $stable(gpo_ff[mio_pkg::OUT_AMP_IDX]))
      else $error("Output 4 changed by write while mapped.");

   AST_READBACK: assert property (
      I_RD && I_ADDR == mio_pkg::OFS_RB0 |=> O_RDATA == sext($past(cfg_ff[3:0])))
      else $error("Readback does not match configuration.");

endmodule // mio_top
`default_nettype wire

// ===== sim/mio_switch_model.sv
// Behavioural limit and latch switches wired to the pins of the block.
`timescale 1ns/1ps
`default_nettype none
module mio_switch_model (
   input wire logic i_wired_high,
   input wire logic [7:0] i_fwd_on,
   input wire logic [7:0] i_rev_on,
   input wire logic [7:0] i_latch_on,
   output logic [7:0] o_lim_fwd,
   output logic [7:0] o_lim_rev,
   output logic [7:0] o_latch
);
   // A closed switch drives its pin to the wired level, an open one to the other.
   assign o_lim_fwd = i_wired_high ? i_fwd_on : ~i_fwd_on;
   assign o_lim_rev = i_wired_high ? i_rev_on : ~i_rev_on;
   assign o_latch = i_wired_high ? i_latch_on : ~i_latch_on;
endmodule // mio_switch_model
`default_nettype wire

// ===== sim/tb_mio_top.sv
// Self-checking testbench for the motion input/output configuration block.
`timescale 1ns/1ps
`default_nettype none
module tb_mio_top;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic [7:0] addr = 8'h00;
   logic [31:0] wdata = 32'h00000000;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic [7:0] fwd_on = 8'h00;
   logic [7:0] rev_on = 8'h00;
   logic [7:0] latch_on = 8'h00;
   logic sw_high = 1'b0;
   logic [7:0] home = 8'h00;
   logic [15:0] gpin = 16'h0000;
   logic abort = 1'b0;
   logic run = 1'b0;
   logic servo = 1'b0;
   wire logic [7:0] lim_f;
   wire logic [7:0] lim_r;
   wire logic [7:0] lat;
   logic [31:0] rdata;
   logic [7:0] fwd_act, rev_act, home_fwd, latch_act, sel_ab, dout;
   logic [15:0] gpin_o;
   logic lim_ev, stop, pe_start, amp_en, irq;
   logic [23:0] cfg = mio_pkg::CFG_RST;
   int err_total = 0;
   int checked = 0;
   int stop_cnt = 0;
   int pe_cnt = 0;
   int le_cnt = 0;

   always #12.5 clk = ~clk;

   mio_switch_model sw (.i_wired_high(sw_high), .i_fwd_on(fwd_on), .i_rev_on(rev_on),
      .i_latch_on(latch_on), .o_lim_fwd(lim_f), .o_lim_rev(lim_r), .o_latch(lat));

   mio_top dut (.I_CLK(clk), .I_RSTN(rst_n), .I_ADDR(addr), .I_WDATA(wdata), .I_WR(wr),
      .I_RD(rd), .O_RDATA(rdata), .I_LIM_FWD(lim_f), .I_LIM_REV(lim_r), .I_HOME(home),
      .I_LATCH(lat), .I_GPIN(gpin), .I_ABORT(abort), .I_PROG_RUN(run), .I_SERVO_ON(servo),
      .O_LIM_FWD_ACT(fwd_act), .O_LIM_REV_ACT(rev_act), .O_HOME_FWD(home_fwd),
      .O_LATCH_ACT(latch_act), .O_SEL_ABORT(sel_ab), .O_GPIN(gpin_o), .O_LIMIT_EVENT(lim_ev),
      .O_PROG_STOP(stop), .O_POSITION_ERROR_ROUTINE_START(pe_start), .O_AMP_EN(amp_en), .O_DOUT(dout),
      .O_IRQ(irq));

   // Pulses are counted on the falling edge, where registered outputs are settled.
   always @(negedge clk) begin
      if (stop === 1'b1) stop_cnt++;
      if (pe_start === 1'b1) pe_cnt++;
      if (lim_ev === 1'b1) le_cnt++;
   end

   // ---------------------------------------------------------------
   // Shared tasks
   // ---------------------------------------------------------------
   task automatic print_verdict();
      $display("mismatches %0d comparisons %0d", err_total, checked);
      if (err_total == 0 && checked > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      checked++;
      if (got !== exp) begin
         err_total++;
         $display("MISMATCH %s expected %h seen %h", nm, exp, got);
      end
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask

   task automatic bus_wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      wr <= 1'b1;
      addr <= a;
      wdata <= d;
      @(posedge clk);
      wr <= 1'b0;
   endtask

   task automatic rd_chk(input string nm, input logic [7:0] a, input logic [31:0] exp);
      @(posedge clk);
      rd <= 1'b1;
      addr <= a;
      @(posedge clk);
      rd <= 1'b0;
      #1;
      chk(nm, exp, rdata);
   endtask

   task automatic set_arg(input int k, input logic [3:0] nib);
      cfg[4*k +: 4] = nib;
      bus_wr(mio_pkg::OFS_CFG, {8'h00, cfg});
   endtask

   // ---------------------------------------------------------------
   // Scenarios
   // ---------------------------------------------------------------
   task automatic t_reset();
      for (int k = 0; k < 6; k++) begin
         rd_chk("readback", 8'(mio_pkg::OFS_RB0 + 4*k), (k < 3) ? 32'hFFFFFFFF : 32'h0);
      end
      rd_chk("unmapped", 8'h40, 32'h0);
   endtask

   task automatic t_limit();
      bus_wr(mio_pkg::OFS_MASK, 32'h1);
      @(posedge clk);
      fwd_on <= 8'h04;
      rev_on <= 8'h80;
      cyc(6);
      chk("limit fwd", 32'h04, 32'(fwd_act));
      chk("limit rev", 32'h80, 32'(rev_act));
      chk("limit events", 32'h1, 32'(le_cnt));
      chk("irq set", 32'h1, 32'(irq));
      bus_wr(mio_pkg::OFS_STAT, 32'h1);
      cyc(3);
      chk("irq cleared", 32'h0, 32'(irq));
      set_arg(mio_pkg::FLD_LIMIT, mio_pkg::NIB_POS);
      cyc(3);
      chk("limit fwd high pol", 32'hFB, 32'(fwd_act));
      chk("limit events flip", 32'h2, 32'(le_cnt));
      @(posedge clk);
      sw_high <= 1'b1;
      cyc(5);
      chk("limit fwd wired high", 32'h04, 32'(fwd_act));
      @(posedge clk);
      fwd_on <= 8'h00;
      rev_on <= 8'h00;
   endtask

   task automatic t_home_latch();
      @(posedge clk);
      home <= 8'hF0;
      latch_on <= 8'h81;
      cyc(5);
      chk("home backward", 32'h0F, 32'(home_fwd));
      chk("latch low", 32'h7E, 32'(latch_act));
      set_arg(mio_pkg::FLD_HOME, mio_pkg::NIB_POS);
      set_arg(mio_pkg::FLD_LATCH, mio_pkg::NIB_POS);
      cyc(3);
      chk("home forward", 32'hF0, 32'(home_fwd));
      chk("latch high", 32'h81, 32'(latch_act));
      @(posedge clk);
      latch_on <= 8'h00;
   endtask

   task automatic t_sel_abort();
      set_arg(mio_pkg::FLD_SELAB, mio_pkg::NIB_POS);
      @(posedge clk);
      gpin <= 16'h1011;
      cyc(5);
      chk("sel abort", 32'h11, 32'(sel_ab));
      chk("gpin masked", 32'h0001, 32'(gpin_o));
      chk("position_error_routine idle", 32'h0, 32'(pe_cnt));
      @(posedge clk);
      gpin <= 16'h0000;
      run <= 1'b1;
      cyc(5);
      @(posedge clk);
      gpin <= 16'h1011;
      cyc(5);
      chk("position_error_routine start", 32'h1, 32'(pe_cnt));
      set_arg(mio_pkg::FLD_SELAB, mio_pkg::NIB_ZERO);
      cyc(3);
      chk("sel abort off", 32'h0, 32'(sel_ab));
      chk("gpin general", 32'h1011, 32'(gpin_o));
   endtask

   task automatic t_abort();
      bus_wr(mio_pkg::OFS_STAT, 32'hF);
      @(posedge clk);
      abort <= 1'b1;
      cyc(5);
      chk("prog stop", 32'h1, 32'(stop_cnt));
      rd_chk("status", mio_pkg::OFS_STAT, 32'h8);
      chk("irq masked", 32'h0, 32'(irq));
      @(posedge clk);
      abort <= 1'b0;
      set_arg(mio_pkg::FLD_ABORT, mio_pkg::NIB_POS);
      @(posedge clk);
      abort <= 1'b1;
      cyc(5);
      chk("no prog stop", 32'h1, 32'(stop_cnt));
      @(posedge clk);
      abort <= 1'b0;
   endtask

   task automatic t_amp();
      @(posedge clk);
      servo <= 1'b1;
      cyc(3);
      chk("amp enable", 32'h1, 32'(amp_en));
      chk("dout general", 32'h0, 32'(dout));
      bus_wr(mio_pkg::OFS_OUT_SET, 32'h4);
      cyc(2);
      chk("dout set", 32'h08, 32'(dout));
      bus_wr(mio_pkg::OFS_OUT_CLR, 32'h4);
      set_arg(mio_pkg::FLD_AMPMAP, mio_pkg::NIB_POS);
      cyc(3);
      chk("dout mapped", 32'h08, 32'(dout));
      bus_wr(mio_pkg::OFS_OUT_CLR, 32'h4);
      bus_wr(mio_pkg::OFS_OUT_PORT, 32'h08);
      bus_wr(mio_pkg::OFS_OUT_BIT, 32'h104);
      cyc(2);
      chk("dout writes ignored", 32'h08, 32'(dout));
      @(posedge clk);
      servo <= 1'b0;
      cyc(3);
      chk("dout motor off", 32'h0, 32'(dout));
      chk("amp disable", 32'h0, 32'(amp_en));
      bus_wr(mio_pkg::OFS_OUT_SET, 32'h4);
      bus_wr(mio_pkg::OFS_OUT_SET, 32'h1);
      cyc(2);
      chk("dout other bits", 32'h01, 32'(dout));
      set_arg(mio_pkg::FLD_AMPMAP, mio_pkg::NIB_ZERO);
      cyc(3);
      chk("dout unmapped", 32'h01, 32'(dout));
   endtask

   task automatic t_readback();
      bus_wr(mio_pkg::OFS_CFG, 32'h00111111);
      bus_wr(mio_pkg::OFS_CFG, 32'h00111112);
      for (int k = 0; k < 6; k++) begin
         rd_chk("readback set", 8'(mio_pkg::OFS_RB0 + 4*k), 32'h1);
      end
   endtask

   // ---------------------------------------------------------------
   // Main sequence and watchdog
   // ---------------------------------------------------------------
   initial begin
      repeat (20) @(posedge clk);
      rst_n <= 1'b1;
      cyc(8);
      t_reset();
      t_limit();
      t_home_latch();
      t_sel_abort();
      t_abort();
      t_amp();
      t_readback();
      print_verdict();
   end

   initial begin
      repeat (3000) @(posedge clk);
      err_total++;
      print_verdict();
   end
endmodule // tb_mio_top
`default_nettype wire
